// file: design/pdp_core.sv
`timescale 1ns/1ps
module pdp_core
    import pdp_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK_SYS,
    input  wire logic        ARST_N,
    // Synthesizer pins
    input  wire logic        FIN_PRESCALED,
    input  wire logic        REFERENCE_OSC_IN,
    input  wire logic [3:0]  RATIO_SEL,
    input  wire logic [3:0]  RATIO_SEL_DRIVEN,
    input  wire logic        RESET_PIN,
    input  wire logic        RESET_PIN_DRIVEN,
    // Charge pump and monitors
    output logic             CP_OUT,
    output logic             CP_OE,
    output logic             DIV_MON,
    output logic             REF_MON,
    // Wishbone slave
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic [31:0]      WB_DAT_O,
    output logic             WB_ACK_O
);
    import pdp_pkg::*;

    function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] ofs);
        reg_hit = (adr[3:2] == ofs[3:2]);
    endfunction

    // ----------------------------------------
    // Pin conditioning
    // ----------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_reg;
    logic [PIN_W-1:0] s2_reg;
    logic [PIN_W-1:0] s3_reg;
    logic [PIN_W-1:0] filt_reg;
    logic [PIN_W-1:0] filt_d_reg;
    logic [3:0]       ratio_pin;
    logic             rst_pin;

    assign rst_pin = RESET_PIN_DRIVEN ? RESET_PIN : 1'b0;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pull
            // Pull-up behaviour of an open select input
            assign ratio_pin[gi] = RATIO_SEL_DRIVEN[gi] ? RATIO_SEL[gi] : 1'b1;
        end
    endgenerate

    assign pin_raw = {rst_pin, ratio_pin, REFERENCE_OSC_IN, FIN_PRESCALED};

    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge CLK_SYS or negedge ARST_N) begin
                if (!ARST_N) begin
                    s1_reg[gi]     <= 1'b0;
                    s2_reg[gi]     <= 1'b0;
                    s3_reg[gi]     <= 1'b0;
                    filt_reg[gi]   <= 1'b0;
                    filt_d_reg[gi] <= 1'b0;
                end else begin
                    s1_reg[gi]     <= pin_raw[gi];
                    s2_reg[gi]     <= s1_reg[gi];
                    s3_reg[gi]     <= s2_reg[gi];
                    // Glitch guard: accept only when two stages agree
                    if (s2_reg[gi] == s3_reg[gi]) begin
                        filt_reg[gi] <= s3_reg[gi];
                    end
                    filt_d_reg[gi] <= filt_reg[gi];
                end
            end
        end
    endgenerate

    logic       fin_edge;
    logic       ref_edge;
    logic [3:0] pin_code;
    assign fin_edge = filt_reg[0] & ~filt_d_reg[0];
    assign ref_edge = filt_reg[1] & ~filt_d_reg[1];
    assign pin_code = filt_reg[5:2];

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    logic [7:0]  ctrl_reg;
    logic [7:0]  refdiv_reg;
    logic        ack_reg;
    logic [31:0] dat_reg;
    logic        wb_req;
    logic        hold_rst;
    logic [3:0]  code;

    assign wb_req   = WB_CYC_I & WB_STB_I & ~ack_reg;
    assign hold_rst = filt_reg[6] | ctrl_reg[CTRL_SRST_BIT];
    assign code     = ctrl_reg[CTRL_OVR_BIT] ? ctrl_reg[CTRL_CODE_LSB +: 4] : pin_code;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ctrl_reg   <= CTRL_RST;
            refdiv_reg <= REFDIV_RST;
        end else if (wb_req && WB_WE_I && WB_SEL_I[0]) begin
            if (reg_hit(WB_ADR_I, CTRL_OFS)) begin
                ctrl_reg <= WB_DAT_I[7:0];
            end
            if (reg_hit(WB_ADR_I, REFDIV_OFS)) begin
                refdiv_reg <= WB_DAT_I[7:0];
            end
        end
    end

    pdp_pfd_t pfd_reg;
    pdp_pfd_t pfd_next;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= wb_req;
            dat_reg <= 32'h0000_0000;
            if (wb_req && !WB_WE_I) begin
                if (reg_hit(WB_ADR_I, CTRL_OFS)) begin
                    dat_reg[7:0] <= ctrl_reg;
                end else if (reg_hit(WB_ADR_I, REFDIV_OFS)) begin
                    dat_reg[7:0] <= refdiv_reg;
                end else if (reg_hit(WB_ADR_I, STATUS_OFS)) begin
                    dat_reg[STAT_CODE_LSB +: 4] <= code;
                    dat_reg[STAT_RST_BIT]       <= hold_rst;
                    dat_reg[STAT_SRC_BIT]       <= (pfd_reg == PFD_SRC);
                    dat_reg[STAT_SNK_BIT]       <= (pfd_reg == PFD_SNK);
                end
            end
        end
    end

    assign WB_ACK_O = ack_reg;
    assign WB_DAT_O = dat_reg;

    // ----------------------------------------
    // Feedback divider
    // ----------------------------------------
    logic [5:0] ratio;
    logic [5:0] fb_cnt_reg;
    logic       fb_mon_reg;
    logic       div_edge;

    assign ratio    = RATIO_BASE + {2'b00, code};
    assign div_edge = fin_edge && !hold_rst && (fb_cnt_reg >= ratio - 6'h01);

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            fb_cnt_reg <= 6'h00;
            fb_mon_reg <= 1'b0;
        end else if (hold_rst) begin
            fb_cnt_reg <= 6'h00;
            fb_mon_reg <= 1'b0;
        end else if (fin_edge) begin
            // Ratio change mid-cycle takes effect at the next input edge, since the wrap compare uses the current ratio
            if (div_edge) begin
                fb_cnt_reg <= 6'h00;
                fb_mon_reg <= 1'b1;
            end else begin
                fb_cnt_reg <= fb_cnt_reg + 6'h01;
                if (fb_cnt_reg + 6'h01 >= {1'b0, ratio[5:1]}) begin
                    fb_mon_reg <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Reference prescaler
    // ----------------------------------------
    logic [7:0] rdiv;
    logic [7:0] rf_cnt_reg;
    logic       rf_mon_reg;
    logic       rdiv_edge;

    // Zero is treated as divide by one
    assign rdiv      = (refdiv_reg == 8'h00) ? 8'h01 : refdiv_reg;
    assign rdiv_edge = ref_edge && !hold_rst && (rf_cnt_reg >= rdiv - 8'h01);

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            rf_cnt_reg <= 8'h00;
            rf_mon_reg <= 1'b0;
        end else if (hold_rst) begin
            rf_cnt_reg <= 8'h00;
            rf_mon_reg <= 1'b0;
        end else if (ref_edge) begin
            if (rdiv_edge) begin
                rf_cnt_reg <= 8'h00;
                rf_mon_reg <= (rdiv == 8'h01) ? ~rf_mon_reg : 1'b1;
            end else begin
                rf_cnt_reg <= rf_cnt_reg + 8'h01;
                if (rf_cnt_reg + 8'h01 >= {1'b0, rdiv[7:1]}) begin
                    rf_mon_reg <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // Phase/frequency detector
    // ----------------------------------------
    always_comb begin
        pfd_next = pfd_reg;
        case (pfd_reg)
            PFD_OFF: begin
                // Coincident edges leave the pump off
                if (rdiv_edge && !div_edge) begin
                    pfd_next = PFD_SRC;
                end else if (div_edge && !rdiv_edge) begin
                    pfd_next = PFD_SNK;
                end
            end
            PFD_SRC: begin
                if (div_edge) begin
                    pfd_next = PFD_OFF;
                end
            end
            PFD_SNK: begin
                if (rdiv_edge) begin
                    pfd_next = PFD_OFF;
                end
            end
            default: pfd_next = PFD_OFF;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            pfd_reg <= PFD_OFF;
        end else if (hold_rst) begin
            pfd_reg <= PFD_OFF;
        end else begin
            pfd_reg <= pfd_next;
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CP_OUT  <= 1'b0;
            CP_OE   <= 1'b0;
            DIV_MON <= 1'b0;
            REF_MON <= 1'b0;
        end else begin
            // Pulse width tracks phase error, giving a linear gain
            CP_OUT  <= (pfd_next == PFD_SRC);
            CP_OE   <= !hold_rst && (pfd_next != PFD_OFF);
            DIV_MON <= fb_mon_reg;
            REF_MON <= rf_mon_reg;
        end
    end

endmodule

// file: design/pdp_pkg.sv
package pdp_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] REFDIV_OFS = 4'h4;
    localparam logic [3:0] STATUS_OFS = 4'h8;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int         CTRL_SRST_BIT  = 0;
    localparam int         CTRL_OVR_BIT   = 1;
    localparam int         CTRL_CODE_LSB  = 2;
    localparam logic [7:0] CTRL_RST       = 8'h00;
    localparam logic [7:0] REFDIV_RST     = 8'h01;
    localparam int         STAT_CODE_LSB  = 0;
    localparam int         STAT_RST_BIT   = 4;
    localparam int         STAT_SRC_BIT   = 5;
    localparam int         STAT_SNK_BIT   = 6;

    // ----------------------------------------
    // Divider, pin width and detector states
    // ----------------------------------------
    localparam logic [5:0] RATIO_BASE = 6'h19;
    localparam int         PIN_W      = 7;

    typedef enum logic [2:0] {
        PFD_OFF = 3'b001,
        PFD_SRC = 3'b010,
        PFD_SNK = 3'b100
    } pdp_pfd_t;

endpackage

// file: verification/pdp_chk.sv
`timescale 1ns/1ps
module pdp_chk (
    // Clock and reset
    input wire logic        CLK_SYS,
    input wire logic        ARST_N,
    // Pins
    input wire logic        FIN_PRESCALED,
    input wire logic        REFERENCE_OSC_IN,
    input wire logic        RESET_PIN,
    input wire logic        RESET_PIN_DRIVEN,
    input wire logic        CP_OE,
    input wire logic        DIV_MON,
    input wire logic        REF_MON,
    // Bus
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    wire req  = WB_CYC_I & WB_STB_I;
    wire prst = RESET_PIN & RESET_PIN_DRIVEN;
    chk_ack_once: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    chk_ack_taken: assert property (req && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not answered");
    chk_ack_idle: assert property (!req |=> !WB_ACK_O)
        else $error("ack without request");
    chk_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
        else $error("read data outside ack");
    chk_reset_off: assert property (prst [*6] |-> !CP_OE)
        else $error("pump active in reset");
    chk_reset_clear: assert property (prst [*7] |-> !DIV_MON && !REF_MON)
        else $error("dividers not cleared");
    // Monitors may only move when their own input moved
    chk_div_quiet: assert property ((!prst && $stable(FIN_PRESCALED)) [*8] |=> $stable(DIV_MON))
        else $error("divider monitor moved");
    chk_ref_quiet: assert property ((!prst && $stable(REFERENCE_OSC_IN)) [*8] |=> $stable(REF_MON))
        else $error("reference monitor moved");
endmodule
bind pdp_core pdp_chk pdp_chk_inst (.CLK_SYS, .ARST_N, .FIN_PRESCALED, .REFERENCE_OSC_IN,
    .RESET_PIN, .RESET_PIN_DRIVEN, .CP_OE, .DIV_MON, .REF_MON, .WB_CYC_I, .WB_STB_I,
    .WB_DAT_O, .WB_ACK_O);

// file: verification/pdp_osc.sv
`timescale 1ns/1ps
module pdp_osc (
    // Clock, tuning and output
    input  wire logic       clk,
    input  wire logic [7:0] half_cyc,
    output logic            osc
);
    int   cnt   = 0;
    logic osc_q = 1'b0;
    assign osc = osc_q;
    // Fixed tuning word, no slew: zero stops the oscillator
    always @(posedge clk) begin
        if (half_cyc == 8'h00) begin
            cnt <= 0;
        end else if (cnt + 1 >= half_cyc) begin
            cnt <= 0;
            osc_q <= ~osc_q;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// file: verification/pll_divider_phase_detector_bench.sv
`timescale 1ns/1ps
module pll_divider_phase_detector_bench;
    import pdp_pkg::*;
    logic        clk = 1'b0, arst_n = 1'b0, rst_pin = 1'b0, rst_drv = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, fin, ref_in, dm_q = 1'b0, rm_q = 1'b0;
    logic        cp_out, cp_oe, div_mon, ref_mon, ack;
    logic [3:0]  adr = 4'h0, sel = 4'h0, code = 4'h0, drv = 4'hF;
    logic [7:0]  h_fin = 8'h03, h_ref = 8'h05;
    logic [31:0] dat = 32'h0000_0000, dat_o, q, r;
    int          mismatches = 0, n_checks = 0, seed, i, n, src, snk;
    initial forever #10 clk = ~clk;
    always @(posedge clk) dm_q <= div_mon;
    always @(posedge clk) rm_q <= ref_mon;
    pdp_osc vco_inst (.clk(clk), .half_cyc(h_fin), .osc(fin));
    pdp_osc xtal_inst (.clk(clk), .half_cyc(h_ref), .osc(ref_in));
    pdp_core pdp_core_inst (.CLK_SYS(clk), .ARST_N(arst_n), .FIN_PRESCALED(fin),
        .REFERENCE_OSC_IN(ref_in), .RATIO_SEL(code), .RATIO_SEL_DRIVEN(drv),
        .RESET_PIN(rst_pin), .RESET_PIN_DRIVEN(rst_drv), .CP_OUT(cp_out), .CP_OE(cp_oe),
        .DIV_MON(div_mon), .REF_MON(ref_mon), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        q = dat_o;
        {cyc, stb} <= 2'b00;
        if (k >= 50) begin
            mismatches++;
            summarize();
        end
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 4'hF, 32'h0000_0000);
        chk(q, e);
    endtask
    function automatic logic rise(input logic use_ref);
        rise = use_ref ? (ref_mon && !rm_q) : (div_mon && !dm_q);
    endfunction
    // Cycles between two rising edges of the chosen monitor
    task automatic gap(input logic use_ref);
        for (n = 0; n < 600 && !rise(use_ref); n++) @(posedge clk);
        @(posedge clk);
        for (n = 1; n < 600 && !rise(use_ref); n++) @(posedge clk);
        if (n >= 600) begin
            mismatches++;
            summarize();
        end
    endtask
    initial begin
        seed = 9103;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rst_pin <= 1'b1;
        repeat (8) @(posedge clk);
        chk({cp_oe, div_mon, ref_mon}, 32'h0000_0000);
        rd(CTRL_OFS, 32'h0000_0000);
        rd(REFDIV_OFS, 32'h0000_0001);
        rd(4'hC, 32'h0000_0000);
        wb(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
        r = $random(seed) | 1;
        wb(1'b1, REFDIV_OFS, 4'hF, r);
        wb(1'b1, REFDIV_OFS, 4'h2, 32'h0000_0003);
        rd(REFDIV_OFS, r & 32'h0000_00FF);
        wb(1'b1, REFDIV_OFS, 4'h1, 32'h0000_0001);
        wb(1'b1, STATUS_OFS, 4'hF, 32'h0000_0000);
        rd(STATUS_OFS, 32'h0000_0010);
        wb(1'b1, CTRL_OFS, 4'h1, 32'h0000_0016);
        rd(STATUS_OFS, 32'h0000_0015);
        wb(1'b1, CTRL_OFS, 4'h1, 32'h0000_0000);
        drv <= 4'h0;
        // Reference held still so no detector event lands in the status read
        h_ref <= 8'h00;
        repeat (8) @(posedge clk);
        rd(STATUS_OFS, 32'h0000_001F);
        drv <= 4'hF;
        rst_drv <= 1'b0;
        repeat (8) @(posedge clk);
        rd(STATUS_OFS, 32'h0000_0000);
        h_ref <= 8'h05;
        for (i = 0; i < 16; i++) begin
            rst_drv <= 1'b1;
            code <= i[3:0];
            repeat (8) @(posedge clk);
            rst_drv <= 1'b0;
            gap(1'b0);
            chk(n, (25 + i) * 2 * 3);
        end
        code <= 4'h0;
        repeat (600) @(posedge clk);
        src = 0;
        snk = 0;
        for (i = 0; i < 300; i++) begin
            @(posedge clk);
            src += int'(cp_oe & cp_out);
            snk += int'(cp_oe & !cp_out);
        end
        chk({31'h0, src > 0}, 32'h0000_0001);
        chk(snk, 32'h0000_0000);
        wb(1'b1, REFDIV_OFS, 4'h1, 32'h0000_0003);
        // Let edges from the old prescale drain first
        repeat (40) @(posedge clk);
        gap(1'b1);
        chk(n, 3 * 2 * 5);
        h_ref <= 8'h00;
        repeat (600) @(posedge clk);
        chk({cp_oe, cp_out}, 32'h0000_0002);
        h_fin <= 8'h00;
        repeat (40) @(posedge clk);
        chk({cp_oe, cp_out, div_mon ^ dm_q}, 32'h0000_0004);
        summarize();
    end
endmodule
